// ==== shared/ttc_pkg.sv ====
// Purpose: constants and types for the timer clock and third timer block
// Assumes: 8-bit special function register bus of the core
// Notes:   offsets are register addresses on that bus
package ttc_pkg;

   // ----------------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] TTC_TIMER_CLOCK_CONTROL_ADDR   = 8'h8E;
   localparam logic [7:0] TTC_EXTERNAL_DATA_PAGE_ADDR    = 8'h92;
   localparam logic [7:0] TTC_THIRD_TIMER_CONTROL_ADDR   = 8'hC8;
   localparam logic [7:0] TTC_THIRD_TIMER_RELOAD_LO_ADDR = 8'hCA;
   localparam logic [7:0] TTC_THIRD_TIMER_RELOAD_HI_ADDR = 8'hCB;
   localparam logic [7:0] TTC_THIRD_TIMER_COUNT_LO_ADDR  = 8'hCC;
   localparam logic [7:0] TTC_THIRD_TIMER_COUNT_HI_ADDR  = 8'hCD;

   // ----------------------------------------------------------------
   // reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] TTC_CLOCK_CONTROL_RST = 8'h01;
   localparam logic [7:0] TTC_PAGE_RST          = 8'h00;
   localparam logic [7:0] TTC_CONTROL_RST       = 8'h00;
   localparam logic [7:0] TTC_RELOAD_RST        = 8'h00;
   localparam logic [7:0] TTC_COUNT_RST         = 8'h00;
   localparam logic [7:0] TTC_CLOCK_CONTROL_WMASK = 8'h3F; // bits 7:6 read zero
   localparam int TTC_FIRST_FAST_BIT  = 3;
   localparam int TTC_WAIT_LSB        = 0;
   localparam int TTC_WAIT_W          = 3;
   localparam int TTC_OVF_FLAG_BIT    = 7;
   localparam int TTC_RX_SEL_BIT      = 5;
   localparam int TTC_TX_SEL_BIT      = 4;
   localparam int TTC_RUN_BIT         = 2;
   localparam int TTC_NUM_TIMERS      = 3;

   // ----------------------------------------------------------------
   // timing: core clocks per increment
   // ----------------------------------------------------------------
   localparam int TTC_SLOW_DIV     = 12;
   localparam int TTC_FAST_DIV     = 4;
   localparam int TTC_BAUD_DIV     = 2;
   localparam int TTC_INSTR_CLOCKS = 4;
   localparam int TTC_DIV_W        = 4;
   localparam logic [15:0] TTC_COUNT_TOP = 16'hFFFF;

   // increment rate of one prescaler
   typedef enum logic [1:0] {
      TTC_RATE_OFF  = 2'b00,
      TTC_RATE_SLOW = 2'b01,
      TTC_RATE_FAST = 2'b10,
      TTC_RATE_BAUD = 2'b11
   } ttc_rate_t;

   // one access on the special function register bus
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } ttc_sfr_req_t;

   // external move addressing
   typedef struct packed {
      logic [15:0] addr;
      logic [2:0]  wait_cycles;
   } ttc_movx_t;

endpackage

// ==== design/ttc_prescaler.sv ====
// Purpose: divides the core clock into one-cycle increment ticks
// Assumes: rate input from logic on the same clock
// Notes:   a rate change restarts the division from zero
`timescale 1ns/100ps
module ttc_prescaler
   import ttc_pkg::*;
(
   input  wire logic      clock,
   input  wire logic      rst_n,
   input  wire ttc_rate_t rate,
   output logic           tick
);

   logic [TTC_DIV_W-1:0] cnt_r;
   logic [TTC_DIV_W-1:0] cnt_nxt;
   logic [TTC_DIV_W-1:0] last_w;
   ttc_rate_t            rate_r;
   logic                 restart_w;
   logic                 wrap_w;
   logic                 tick_nxt;

   // --------------------------------------------------------------
   // terminal count per rate
   // --------------------------------------------------------------
   assign last_w = (rate == TTC_RATE_FAST) ? TTC_DIV_W'(TTC_FAST_DIV - 1) :
                   (rate == TTC_RATE_BAUD) ? TTC_DIV_W'(TTC_BAUD_DIV - 1) :
                                             TTC_DIV_W'(TTC_SLOW_DIV - 1);
   assign restart_w = (rate != rate_r) || (rate == TTC_RATE_OFF);
   assign wrap_w    = (cnt_r == last_w);
   assign cnt_nxt   = (restart_w || wrap_w) ? '0 : cnt_r + 1'b1;
   assign tick_nxt  = wrap_w && !restart_w;

   // divider state
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cnt_r  <= '0;
         rate_r <= TTC_RATE_OFF;
         tick   <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         rate_r <= rate;
         tick   <= tick_nxt;
      end
   end

endmodule

// ==== design/ttc_timer_clock_ctrl.sv ====
// Purpose: timer rate selects, external page, third timer control and count
// Assumes: core register bus on the same clock; read data one cycle after rd
// Notes:   event pin of the third timer is asynchronous and synchronised here
`timescale 1ns/100ps

// What this block does
// R1 - Rate-select bit 1 gives one increment per 4 clocks, 0 per 12.
// R2 - Rate-select bits: bit 5 third timer, bit 4 second, bit 3 first.
// R3 - The three rate-select bits act independently of each other.
// R4 - A rate-select bit does nothing while its timer counts external events.
// R5 - Third timer rate-select is ignored in baud rate generator mode.
// R6 - After reset all rate-select bits are 0, giving the slow rate.
// R7 - Instruction cycle is 4 clocks; default timer rate is 12 clocks.
// R8 - Low three bits of clock control set external move wait cycles.
// R9 - Register-indirect external moves drive the page register on address 15:8.
// R10 - Overflow flag sets when the 16-bit count rolls over from all ones.
// R11 - Software alone clears the overflow flag.
// R12 - Overflow flag sets only when both serial clock selects are 0.
// R13 - Writing 1 to the overflow flag raises the third timer interrupt.
// R14 - Receive select 1 times serial receive from third timer, else second.
// R15 - Transmit select 1 times serial transmit from third timer, else second.
// R16 - Third timer counts while its run bit is 1, halts when 0.
// R17 - Software writes 0 to reserved control bits 6, 3, 1 and 0.
// R18 - Low reload register gives bits 7:0 of the reload value.
// R19 - Each overflow copies the 16-bit reload value into the count.
// R20 - Baud mode forces auto-reload and a time base of clock over two.
// R21 - High reload register gives bits 15:8 of the reload value.
// R22 - Clock control bits 7 and 6 ignore writes and read zero.
module ttc_timer_clock_ctrl
   import ttc_pkg::*;
#(
   parameter int NUM_TIMERS = TTC_NUM_TIMERS
)
(
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire ttc_sfr_req_t sfr_req,
   output logic [7:0]        sfr_rdata,
   input  wire logic [1:0]   timer_counter_mode,
   input  wire logic         third_timer_counter_mode,
   input  wire logic         third_timer_event_pin,
   input  wire logic         second_timer_overflow,
   input  wire logic         movx_indirect,
   input  wire logic [7:0]   movx_pointer,
   output ttc_movx_t         movx,
   output logic [1:0]        timer_increment,
   output logic              third_timer_out,
   output logic              third_timer_irq,
   output logic              serial_rx_clock,
   output logic              serial_tx_clock
);

   // --------------------------------------------------------------
   // elaboration check
   // --------------------------------------------------------------
   if (NUM_TIMERS != TTC_NUM_TIMERS) begin : g_bad_count
      $error("timer count must be three");
   end

   // register address hit
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
      hit = (addr == reg_addr);
   endfunction

   // --------------------------------------------------------------
   // registers
   // --------------------------------------------------------------
   logic [7:0]  timer_clock_control_r;
   logic [7:0]  external_data_page_r;
   logic        third_timer_overflow_flag_r;
   logic        serial_receive_clock_select_r;
   logic        serial_transmit_clock_select_r;
   logic        third_timer_run_r;
   logic [7:0]  third_timer_reload_low_r;
   logic [7:0]  third_timer_reload_high_r;
   logic [15:0] count_r;
   logic [15:0] count_nxt;
   logic        flag_nxt;
   logic [7:0]  rdata_nxt;
   logic [2:0]  ev_sync_r;

   // decoded writes
   wire wr_ckc_w   = sfr_req.wr && hit(sfr_req.addr, TTC_TIMER_CLOCK_CONTROL_ADDR);
   wire wr_page_w  = sfr_req.wr && hit(sfr_req.addr, TTC_EXTERNAL_DATA_PAGE_ADDR);
   wire wr_ctl_w   = sfr_req.wr && hit(sfr_req.addr, TTC_THIRD_TIMER_CONTROL_ADDR);
   wire wr_rlo_w   = sfr_req.wr && hit(sfr_req.addr, TTC_THIRD_TIMER_RELOAD_LO_ADDR);
   wire wr_rhi_w   = sfr_req.wr && hit(sfr_req.addr, TTC_THIRD_TIMER_RELOAD_HI_ADDR);
   wire wr_clo_w   = sfr_req.wr && hit(sfr_req.addr, TTC_THIRD_TIMER_COUNT_LO_ADDR);
   wire wr_chi_w   = sfr_req.wr && hit(sfr_req.addr, TTC_THIRD_TIMER_COUNT_HI_ADDR);

   // --------------------------------------------------------------
   // rate selection per timer
   // --------------------------------------------------------------
   wire        baud_mode_w = serial_receive_clock_select_r
                             || serial_transmit_clock_select_r;
   wire [2:0]  fast_w      = timer_clock_control_r[TTC_FIRST_FAST_BIT +: TTC_NUM_TIMERS]; // R2
   wire [2:0]  cmode_w     = {third_timer_counter_mode, timer_counter_mode};
   ttc_rate_t  rate_w [TTC_NUM_TIMERS];
   logic       tick_w [TTC_NUM_TIMERS];

   // one independent prescaler per timer
   for (genvar i = 0; i < TTC_NUM_TIMERS; i++) begin : g_pre
      if (i == TTC_NUM_TIMERS - 1) begin : g_third
         assign rate_w[i] = baud_mode_w ? TTC_RATE_BAUD :        // R5 R20
                            (!third_timer_run_r || cmode_w[i]) ? TTC_RATE_OFF :
                            fast_w[i] ? TTC_RATE_FAST : TTC_RATE_SLOW;
      end else begin : g_basic
         assign rate_w[i] = cmode_w[i] ? TTC_RATE_OFF :         // R4
                            fast_w[i] ? TTC_RATE_FAST : TTC_RATE_SLOW; // R1 R3 R7
      end
      ttc_prescaler u_pre (
         .clock (clock),
         .rst_n (rst_n),
         .rate  (rate_w[i]),
         .tick  (tick_w[i])
      );
   end

   // --------------------------------------------------------------
   // third timer increment, overflow and reload
   // --------------------------------------------------------------
   wire ev_edge_w = ev_sync_r[2] && !ev_sync_r[1]; // falling edge on the pin
   wire inc_w     = third_timer_run_r &&                        // R16
                    (baud_mode_w ? tick_w[2] :
                     third_timer_counter_mode ? ev_edge_w : tick_w[2]);
   wire ovf_w     = inc_w && (count_r == TTC_COUNT_TOP);        // R10
   wire [15:0] reload_w = {third_timer_reload_high_r,           // R21
                           third_timer_reload_low_r};           // R18

   // next count: software write wins over counting
   always_comb begin
      count_nxt = count_r;
      if (ovf_w) begin
         count_nxt = reload_w;                                  // R19 R20
      end else if (inc_w) begin
         count_nxt = count_r + 16'h0001;
      end
      if (wr_clo_w) begin
         count_nxt[7:0] = sfr_req.wdata;
      end
      if (wr_chi_w) begin
         count_nxt[15:8] = sfr_req.wdata;
      end
   end

   // overflow flag: hardware set beats software clear
   assign flag_nxt = (ovf_w && !baud_mode_w) ||                 // R12
                     (wr_ctl_w ? sfr_req.wdata[TTC_OVF_FLAG_BIT] // R13
                               : third_timer_overflow_flag_r);  // R11

   // --------------------------------------------------------------
   // read data selection
   // --------------------------------------------------------------
   wire [7:0] ctl_read_w = {third_timer_overflow_flag_r, 1'b0,
                            serial_receive_clock_select_r,
                            serial_transmit_clock_select_r,
                            1'b0, third_timer_run_r, 2'b00};
   assign rdata_nxt =
      hit(sfr_req.addr, TTC_TIMER_CLOCK_CONTROL_ADDR)   ? timer_clock_control_r :
      hit(sfr_req.addr, TTC_EXTERNAL_DATA_PAGE_ADDR)    ? external_data_page_r :
      hit(sfr_req.addr, TTC_THIRD_TIMER_CONTROL_ADDR)   ? ctl_read_w :
      hit(sfr_req.addr, TTC_THIRD_TIMER_RELOAD_LO_ADDR) ? third_timer_reload_low_r :
      hit(sfr_req.addr, TTC_THIRD_TIMER_RELOAD_HI_ADDR) ? third_timer_reload_high_r :
      hit(sfr_req.addr, TTC_THIRD_TIMER_COUNT_LO_ADDR)  ? count_r[7:0] :
      hit(sfr_req.addr, TTC_THIRD_TIMER_COUNT_HI_ADDR)  ? count_r[15:8] : 8'h00;

   // --------------------------------------------------------------
   // register writes
   // --------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         timer_clock_control_r <= TTC_CLOCK_CONTROL_RST;          // R6
         external_data_page_r  <= TTC_PAGE_RST;
      end else begin
         if (wr_ckc_w) begin
            timer_clock_control_r <= sfr_req.wdata & TTC_CLOCK_CONTROL_WMASK; // R22
         end
         if (wr_page_w) begin
            external_data_page_r <= sfr_req.wdata;
         end
      end
   end

   // third timer control; reserved bits are not stored
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         third_timer_overflow_flag_r    <= TTC_CONTROL_RST[TTC_OVF_FLAG_BIT];
         serial_receive_clock_select_r  <= TTC_CONTROL_RST[TTC_RX_SEL_BIT];
         serial_transmit_clock_select_r <= TTC_CONTROL_RST[TTC_TX_SEL_BIT];
         third_timer_run_r              <= TTC_CONTROL_RST[TTC_RUN_BIT];
      end else begin
         third_timer_overflow_flag_r <= flag_nxt;
         if (wr_ctl_w) begin                                      // R17
            serial_receive_clock_select_r  <= sfr_req.wdata[TTC_RX_SEL_BIT];
            serial_transmit_clock_select_r <= sfr_req.wdata[TTC_TX_SEL_BIT];
            third_timer_run_r              <= sfr_req.wdata[TTC_RUN_BIT];
         end
      end
   end

   // reload and count
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         third_timer_reload_low_r  <= TTC_RELOAD_RST;
         third_timer_reload_high_r <= TTC_RELOAD_RST;
         count_r                   <= {TTC_COUNT_RST, TTC_COUNT_RST};
      end else begin
         if (wr_rlo_w) begin
            third_timer_reload_low_r <= sfr_req.wdata;
         end
         if (wr_rhi_w) begin
            third_timer_reload_high_r <= sfr_req.wdata;
         end
         count_r <= count_nxt;
      end
   end

   // event pin synchroniser plus edge stage
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ev_sync_r <= 3'b000;
      end else begin
         ev_sync_r <= {ev_sync_r[1:0], third_timer_event_pin};
      end
   end

   // --------------------------------------------------------------
   // registered outputs
   // --------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sfr_rdata       <= 8'h00;
         movx            <= '0;
         timer_increment <= 2'b00;
         third_timer_out <= 1'b0;
         third_timer_irq <= 1'b0;
         serial_rx_clock <= 1'b0;
         serial_tx_clock <= 1'b0;
      end else begin
         sfr_rdata        <= sfr_req.rd ? rdata_nxt : 8'h00;
         movx.addr        <= movx_indirect ? {external_data_page_r, movx_pointer} // R9
                                           : movx.addr;
         movx.wait_cycles <= timer_clock_control_r[TTC_WAIT_LSB +: TTC_WAIT_W];   // R8
         timer_increment  <= {tick_w[1], tick_w[0]};
         third_timer_out  <= ovf_w;
         third_timer_irq  <= flag_nxt;                             // R13
         serial_rx_clock  <= serial_receive_clock_select_r ? ovf_w            // R14
                                                           : second_timer_overflow;
         serial_tx_clock  <= serial_transmit_clock_select_r ? ovf_w           // R15
                                                            : second_timer_overflow;
      end
   end

   // --------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   fast_rate_a: assert property ( // R1
      (tick_w[0] && rate_w[0] == TTC_RATE_FAST) ##1 (rate_w[0] == TTC_RATE_FAST)[*4]
      |-> tick_w[0])
      else $error("fast first timer did not tick after four clocks");
   slow_gap_a: assert property ( // R7
      (tick_w[1] && rate_w[1] == TTC_RATE_SLOW) ##1 (rate_w[1] == TTC_RATE_SLOW)[*8]
      |-> !tick_w[1])
      else $error("slow second timer ticked too early");
   reset_rate_a: assert property ( // R6
      $rose(rst_n) |-> fast_w == 3'b000 && timer_clock_control_r == TTC_CLOCK_CONTROL_RST)
      else $error("clock control not at reset value");
   counter_quiet_a: assert property ( // R4
      cmode_w[0] [*2] |-> !tick_w[0])
      else $error("first timer ticked in counter mode");
   baud_rate_a: assert property ( // R5
      (tick_w[2] && baud_mode_w) ##1 baud_mode_w[*2] |-> tick_w[2])
      else $error("baud mode time base not clock over two");
   flag_set_a: assert property ( // R10
      ovf_w && !baud_mode_w |=> third_timer_overflow_flag_r && third_timer_out)
      else $error("overflow did not set flag");
   flag_block_a: assert property ( // R12
      !third_timer_overflow_flag_r && baud_mode_w && !wr_ctl_w |=> !third_timer_overflow_flag_r)
      else $error("flag set in baud mode");
   flag_hold_a: assert property ( // R11
      third_timer_overflow_flag_r && !wr_ctl_w |=> third_timer_overflow_flag_r)
      else $error("flag cleared without software");
   reload_copy_a: assert property ( // R19
      ovf_w && !wr_clo_w && !wr_chi_w |=> count_r == $past(reload_w))
      else $error("overflow did not reload count");
   halt_stable_a: assert property ( // R16
      !third_timer_run_r && !wr_clo_w && !wr_chi_w |=> count_r == $past(count_r))
      else $error("stopped timer changed count");
   page_drive_a: assert property ( // R9
      movx_indirect |=> movx.addr[15:8] == $past(external_data_page_r))
      else $error("page register not on upper address");
   reserved_zero_a: assert property ( // R22
      sfr_req.rd && hit(sfr_req.addr, TTC_TIMER_CLOCK_CONTROL_ADDR) |=> sfr_rdata[7:6] == 2'b00)
      else $error("reserved clock control bits not zero");

   overflow_c: cover property (ovf_w && !baud_mode_w);
   baud_tx_c:  cover property (serial_transmit_clock_select_r && ovf_w);
   soft_irq_c: cover property (wr_ctl_w && sfr_req.wdata[TTC_OVF_FLAG_BIT] ##1 third_timer_irq);
   fast_all_c: cover property (fast_w == 3'b111);

endmodule

// ==== dv/ttc_core_model.sv ====
// Purpose: core side of the special function register bus
// Assumes: one request per call, strobes one cycle wide
// Notes:   after the first request an idle bus carries inverted leftovers, not zeros
`timescale 1ns/100ps
module ttc_core_model
   import ttc_pkg::*;
(
   input  wire logic       clock,
   output ttc_sfr_req_t    sfr_req,
   input  wire logic [7:0] sfr_rdata
);
   // ----------------------------------------------------------------
   // bus cycles
   // ----------------------------------------------------------------
   // idle bus at time zero
   initial sfr_req = '0;

   // one write strobe, then release with scrambled leftovers
   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = (a == TTC_THIRD_TIMER_CONTROL_ADDR) ? (d & 8'hB4) : d;
      @(posedge clock);
      sfr_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
      @(posedge clock);
      sfr_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~v};
   endtask

   // one read strobe, data taken in the cycle after the read edge
   task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      sfr_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'hA5};
      @(posedge clock);
      sfr_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'h5A};
      #1;
      d = sfr_rdata;
   endtask
endmodule

// ==== dv/tb.sv ====
// Purpose: self-checking bench for the timer clock and third timer block
// Assumes: register model kept here, bus cycles from the core model
// Notes:   counts are compared while the third timer is stopped, except one read just after an overflow reload
`timescale 1ns/100ps
module tb;
   import ttc_pkg::*;
   logic         clock, rst_n, t2cm, evp, sto, mvi, t2o, irq, rxc, txc;
   logic [1:0]   tcm, tinc;
   logic [7:0]   sfr_rdata, mvp, rv;
   logic [31:0]  rnd;
   ttc_sfr_req_t sfr_req;
   ttc_movx_t    movx;
   int           errors, checked, c;
   logic [7:0]   mdl [logic [7:0]];
   logic [7:0]   regs [$] = '{8'h8E, 8'h92, 8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'h55};

   // ----------------------------------------------------------------
   // clock, design and bus partner
   // ----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   ttc_timer_clock_ctrl i_dut (.clock(clock), .rst_n(rst_n), .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata), .timer_counter_mode(tcm), .third_timer_counter_mode(t2cm),
      .third_timer_event_pin(evp), .second_timer_overflow(sto), .movx_indirect(mvi),
      .movx_pointer(mvp), .movx(movx), .timer_increment(tinc), .third_timer_out(t2o),
      .third_timer_irq(irq), .serial_rx_clock(rxc), .serial_tx_clock(txc));
   ttc_core_model i_core (.clock(clock), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] r);
      return {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
   endfunction
   // writable bits of each register
   function automatic logic [7:0] wmask(input logic [7:0] a);
      case (a)
         8'h8E: wmask = 8'h3F;
         8'h92, 8'hCA, 8'hCB, 8'hCC, 8'hCD: wmask = 8'hFF;
         8'hC8: wmask = 8'hB4;
         default: wmask = 8'h00;
      endcase
   endfunction
   function automatic logic sig(input int w);
      case (w)
         0: sig = tinc[0];
         1: sig = tinc[1];
         2: sig = t2o;
         3: sig = rxc;
         default: sig = txc;
      endcase
   endfunction
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_core.sfr_write(a, d);
      mdl[a] = d & wmask(a);
   endtask
   task automatic rdc(input logic [7:0] a);
      logic [7:0] d;
      i_core.sfr_read(a, d);
      chk($sformatf("register %h", a), {8'h00, d}, {8'h00, mdl[a]});
   endtask
   // bounded wait for a pulse, c is the number of edges waited
   task automatic wait_sig(input int w, output int c);
      for (c = 1; c <= 400; c++) begin
         @(posedge clock);
         #1;
         if (sig(w) === 1'b1) return;
      end
      chk($sformatf("pulse %0d", w), 16'h0000, 16'h0001);
      wrap_up();
   endtask
   // the first pulse may predate a rate change and the second follows the restart
   task automatic per(input int w, output int c);
      wait_sig(w, c);
      wait_sig(w, c);
      wait_sig(w, c);
   endtask
   // one-cycle overflow pulse from the second timer
   task automatic pulse_sto;
      @(posedge clock);
      sto <= 1'b1;
      @(posedge clock);
      sto <= 1'b0;
      #1;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      errors = 0; checked = 0; rnd = 32'h854282A4; rst_n = 1'b0; tcm = 2'b00;
      t2cm = 1'b0; evp = 1'b1; sto = 1'b0; mvi = 1'b0; mvp = 8'h00;
      foreach (regs[i]) mdl[regs[i]] = 8'h00;
      mdl[8'h8E] = TTC_CLOCK_CONTROL_RST;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      foreach (regs[i]) rdc(regs[i]);
      per(0, c); chk("first period", c[15:0], 16'd12);
      $display("test reset done");
      foreach (regs[i]) if (regs[i] != 8'hC8) begin
         rnd = lfsr(rnd);
         wr(regs[i], rnd[7:0]);
         rdc(regs[i]);
      end
      chk("wait cycles", {13'h0000, movx.wait_cycles}, {13'h0000, mdl[8'h8E][2:0]});
      rnd = lfsr(rnd);
      @(posedge clock);
      mvi <= 1'b1;
      mvp <= rnd[7:0];
      @(posedge clock);
      mvi <= 1'b0;
      #1 chk("movx addr", movx.addr, {mdl[8'h92], rnd[7:0]});
      $display("test registers done");
      wr(8'h8E, 8'h08);
      per(0, c); chk("first fast", c[15:0], 16'd4);
      per(1, c); chk("second slow", c[15:0], 16'd12);
      wr(8'h8E, 8'h10);
      per(1, c); chk("second fast", c[15:0], 16'd4);
      per(0, c); chk("first slow", c[15:0], 16'd12);
      $display("test rates done");
      wr(8'h8E, 8'h20); wr(8'hCA, 8'h34); wr(8'hCB, 8'h12); wr(8'hCC, 8'hFD);
      wr(8'hCD, 8'hFF); wr(8'hC8, 8'h04);
      wait_sig(2, c);
      mdl[8'hCC] = 8'h34;
      rdc(8'hCC);
      rdc(8'hCA);
      mdl[8'hC8] = 8'h84;
      rdc(8'hC8);
      chk("irq after overflow", {15'h0000, irq}, 16'h0001);
      wr(8'h8E, 8'h00);
      wr(8'hC8, 8'h80); wr(8'hCC, 8'h77);
      repeat (40) @(posedge clock);
      rdc(8'hCC); rdc(8'hC8);
      wr(8'hC8, 8'h00);
      #1 chk("irq cleared", {15'h0000, irq}, 16'h0000);
      wr(8'hC8, 8'h80);
      #1 chk("irq forced", {15'h0000, irq}, 16'h0001);
      wr(8'hC8, 8'h00);
      $display("test overflow done");
      // event counting: no increment ticks and the third timer counts pin edges only
      @(posedge clock);
      tcm <= 2'b11;
      repeat (3) @(posedge clock);
      c = 0;
      repeat (30) begin
         @(posedge clock);
         #1 c += int'(tinc != 2'b00);
      end
      chk("counter quiet", c[15:0], 16'h0000);
      wr(8'h8E, 8'h20);
      t2cm <= 1'b1;
      wr(8'hC8, 8'h04);
      repeat (5) begin
         @(posedge clock);
         evp <= 1'b0;
         repeat (3) @(posedge clock);
         evp <= 1'b1;
         repeat (2) @(posedge clock);
      end
      repeat (4) @(posedge clock);
      wr(8'hC8, 8'h00);
      tcm  <= 2'b00;
      t2cm <= 1'b0;
      mdl[8'hCC] = mdl[8'hCC] + 8'h05;
      rdc(8'hCC);
      $display("test counter mode done");
      wr(8'h8E, 8'h20); wr(8'hCA, 8'hF0); wr(8'hCB, 8'hFF); wr(8'hCC, 8'hF0);
      wr(8'hCD, 8'hFF); wr(8'hC8, 8'h24);
      per(3, c); chk("baud period", c[15:0], 16'd32);
      rdc(8'hC8);
      pulse_sto(); chk("tx from second", {15'h0000, txc}, 16'h0001);
      wr(8'hC8, 8'h14);
      wait_sig(4, c);
      pulse_sto(); chk("rx from second", {15'h0000, rxc}, 16'h0001);
      rdc(8'hC8);
      $display("test baud done");
      wrap_up();
   end
endmodule
